//--- inc/wwd_pkg.sv
// Purpose: constants and types shared by the window watchdog design
// Assumes: 32-bit register port, one clock
// Notes: byte offsets on a word-aligned map
package wwd_pkg;
  localparam int unsigned WWD_CLK_HZ = 50000000;
  localparam int unsigned WWD_ADDR_W = 8;
  localparam logic [7:0] WWD_OFS_CONTROL = 8'h00;
  localparam logic [7:0] WWD_OFS_CONFIG = 8'h04;
  localparam logic [7:0] WWD_OFS_STATUS = 8'h08;
  localparam logic [7:0] WWD_OFS_IRQ_EN = 8'h0C;
  localparam logic [7:0] WWD_OFS_IRQ_CLR = 8'h10;
  localparam int unsigned WWD_RUN_BIT = 7;
  localparam int unsigned WWD_DIV_LO = 7;
  localparam int unsigned WWD_EARLY_WARNING_IRQ_ENABLE_BIT = 9;
  localparam int unsigned WWD_EARLY_WARNING_FLAG_BIT = 0;
  localparam logic [6:0] WWD_CNT_RESET = 7'h7F;
  localparam logic [6:0] WWD_WIN_RESET = 7'h7F;
  localparam logic [6:0] WWD_CNT_WARN = 7'h40;
  localparam logic [6:0] WWD_CNT_TRIP = 7'h3F;
  localparam int unsigned WWD_BASE_DIV = 4096;
  localparam logic [11:0] WWD_BASE_LAST = 12'hFFF;

  typedef enum logic [1:0] {WWD_DIV1, WWD_DIV2, WWD_DIV4, WWD_DIV8} wwd_div_e;

  typedef struct packed {
    logic [WWD_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wwd_bus_s;
endpackage : wwd_pkg

//--- verilog/wwd_tick_gen.sv
// Purpose: time base for the countdown, clock / 4096 / (1,2,4,8)
// Assumes: i_run held high while counting is allowed
// Notes: o_tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module wwd_tick_gen
  import wwd_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // control
  input wire logic i_run,
  input wire wwd_div_e i_div,
  // tick
  output logic o_tick
);
  logic [11:0] base_reg;
  logic [2:0] post_reg;
  logic [2:0] post_last;
  logic base_wrap;

  assign base_wrap = (base_reg == WWD_BASE_LAST);

  always_comb begin
    unique case (i_div)
      WWD_DIV1: post_last = 3'h0;
      WWD_DIV2: post_last = 3'h1;
      WWD_DIV4: post_last = 3'h3;
      WWD_DIV8: post_last = 3'h7;
    endcase
  end

  // divide by 4096 first
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      base_reg <= 12'h000;
    end else if (i_run) begin
      base_reg <= base_reg + 12'h001;
    end
  end

  // then by the selected power of two
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      post_reg <= 3'h0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (i_run && base_wrap) begin
        if (post_reg >= post_last) begin
          post_reg <= 3'h0;
          o_tick <= 1'b1;
        end else begin
          post_reg <= post_reg + 3'h1;
        end
      end
    end
  end
endmodule : wwd_tick_gen
`default_nettype wire

//--- verilog/wwd_irq.sv
// Purpose: sticky event status, enable and clear for one interrupt line
// Assumes: i_set is a one-cycle event pulse
// Notes: set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module wwd_irq
  import wwd_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // event and software access
  input wire logic i_set,
  input wire logic i_clr,
  input wire logic i_en,
  // state
  output logic o_flag,
  output logic o_irq
);
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clr) begin
      o_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= i_en && (o_flag || i_set);
    end
  end
endmodule : wwd_irq
`default_nettype wire

//--- verilog/wwd_top.sv
// Purpose: window watchdog with 7-bit down-counter and early warning
// Assumes: register port strobes are one cycle, never both at once
// Notes: reset request is a one-cycle pulse on o_sys_reset_req
//
// Functional notes
// - reset request when running counter steps from 0x40 to 0x3F
// - reset request when counter written while above window limit
// - stopped after reset; no counting or resets until run bit set
// - run bit 7 is set-only; zero writes ignored; reset clears it
// - running counter decrements every tick, even after a reset condition
// - tick is clock / 4096 / 1,2,4,8 by divider select bits 8:7
// - early-warning flag set by hardware at 0x40, regardless of enable
// - writing zero clears early-warning flag; writing one keeps it
// - enabled early-warning interrupt asserts when counter reaches 0x40
// - early-warning enable bit 9 set-only; hardware or soft reset clears
// - window limit lives in config bits 6:0
// - countdown field reads live counter; write loads new value
// - debug freeze select plus core halt stops counting
// - control and config reset to 0x7F
`timescale 1ns/1ps
`default_nettype none
module wwd_top
  import wwd_pkg::*;
(
  // clock and resets
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_soft_reset,
  // register port
  input wire logic [WWD_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // debug
  input wire logic i_debug_freeze_select,
  input wire logic i_core_halted,
  // outputs
  output logic o_sys_reset_req,
  output logic o_irq
);
  wwd_bus_s bus;
  logic run_reg;
  logic [6:0] cnt_reg;
  logic [6:0] win_reg;
  wwd_div_e div_reg;
  logic early_warning_irq_enable_reg;
  logic irq_en_reg;
  logic tick;
  logic counting;
  logic flag;
  logic ew_irq;
  logic wr_ctl;
  logic wr_cfg;
  logic wr_stat;
  logic wr_clr;
  logic step_trip;
  logic bad_refresh;
  logic reach_warn;
  logic soft_ok_n;

  // bus is an argument so continuous assignments re-evaluate on its changes
  function automatic logic hit(input wwd_bus_s b,
                               input logic [WWD_ADDR_W-1:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction : hit

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign wr_ctl = hit(bus, WWD_OFS_CONTROL);
  assign wr_cfg = hit(bus, WWD_OFS_CONFIG);
  assign wr_stat = hit(bus, WWD_OFS_STATUS);
  assign wr_clr = hit(bus, WWD_OFS_IRQ_CLR);
  assign soft_ok_n = i_reset_n && !i_soft_reset;

  // freeze only when both debug select and halt are present
  assign counting = run_reg && !(i_debug_freeze_select && i_core_halted);

  wwd_tick_gen u_tick (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_run(counting),
    .i_div(div_reg),
    .o_tick(tick)
  );

  assign step_trip = counting && tick && !wr_ctl && (cnt_reg == WWD_CNT_WARN);
  assign bad_refresh = run_reg && wr_ctl && (cnt_reg > win_reg);
  assign reach_warn = counting && tick && !wr_ctl
    && (cnt_reg == WWD_CNT_WARN + 7'h01);

  // run bit: set-only
  always_ff @(posedge i_clk) begin
    if (!soft_ok_n) begin
      run_reg <= 1'b0;
    end else if (wr_ctl && bus.wdata[WWD_RUN_BIT]) begin
      run_reg <= 1'b1;
    end
  end

  // counter: software load beats a tick in the same cycle
  always_ff @(posedge i_clk) begin
    if (!soft_ok_n) begin
      cnt_reg <= WWD_CNT_RESET;
    end else if (wr_ctl) begin
      cnt_reg <= bus.wdata[6:0];
    end else if (counting && tick) begin
      cnt_reg <= cnt_reg - 7'h01;
    end
  end

  // configuration: window, divider, set-only early-warning enable
  always_ff @(posedge i_clk) begin
    if (!soft_ok_n) begin
      win_reg <= WWD_WIN_RESET;
      div_reg <= WWD_DIV1;
      early_warning_irq_enable_reg <= 1'b0;
    end else if (wr_cfg) begin
      win_reg <= bus.wdata[6:0];
      div_reg <= wwd_div_e'(bus.wdata[WWD_DIV_LO+1:WWD_DIV_LO]);
      if (bus.wdata[WWD_EARLY_WARNING_IRQ_ENABLE_BIT]) begin
        early_warning_irq_enable_reg <= 1'b1;
      end
    end
  end

  // gate for the summary interrupt line
  always_ff @(posedge i_clk) begin
    if (!soft_ok_n) begin
      irq_en_reg <= 1'b0;
    end else if (hit(bus, WWD_OFS_IRQ_EN)) begin
      irq_en_reg <= bus.wdata[WWD_EARLY_WARNING_FLAG_BIT];
    end
  end

  wwd_irq u_irq (
    .i_clk(i_clk),
    .i_reset_n(soft_ok_n),
    .i_set(reach_warn),
    .i_clr((wr_stat && !bus.wdata[WWD_EARLY_WARNING_FLAG_BIT])
      || (wr_clr && bus.wdata[WWD_EARLY_WARNING_FLAG_BIT])),
    .i_en(early_warning_irq_enable_reg && irq_en_reg),
    .o_flag(flag),
    .o_irq(ew_irq)
  );

  // one pulse per detected condition
  always_ff @(posedge i_clk) begin
    if (!soft_ok_n) begin
      o_sys_reset_req <= 1'b0;
    end else begin
      o_sys_reset_req <= step_trip || bad_refresh;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!soft_ok_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= ew_irq;
    end
  end

  // read data stand one cycle after the strobe only
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        WWD_OFS_CONTROL: o_rdata <= {24'h00_0000, run_reg, cnt_reg};
        WWD_OFS_CONFIG: o_rdata <= {22'h00_0000, early_warning_irq_enable_reg, div_reg, win_reg};
        WWD_OFS_STATUS: o_rdata <= {31'h0000_0000, flag};
        WWD_OFS_IRQ_EN: o_rdata <= {31'h0000_0000, irq_en_reg};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
endmodule : wwd_top
`default_nettype wire

//--- verif/wwd_assertions.sv
// Purpose: port-level checks for wwd_top
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every wwd_top instance
`timescale 1ns/1ps
`default_nettype none
module wwd_chk
  import wwd_pkg::*;
(
  // clock and resets
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_soft_reset,
  // register port
  input wire logic [WWD_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // debug and outputs
  input wire logic i_debug_freeze_select,
  input wire logic i_core_halted,
  input wire logic o_sys_reset_req,
  input wire logic o_irq
);
  logic run_reg;

  // soft reset left out: it also clears o_sys_reset_req on the same edge
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      run_reg <= 1'b0;
    end else if (i_wr && i_addr == WWD_OFS_CONTROL && i_wdata[7]) begin
      run_reg <= 1'b1;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  idle_rdata_a: assert property (
    !i_rd |=> o_rdata == 32'h0) else $error("read data not idle");
  unmapped_read_a: assert property (
    i_rd && i_addr == 8'h14 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_fields_a: assert property (
    i_rd && i_addr == WWD_OFS_CONTROL |=> o_rdata[31:8] == 24'h0)
    else $error("control spare bits set");
  cfg_fields_a: assert property (
    i_rd && i_addr == WWD_OFS_CONFIG |=> o_rdata[31:10] == 22'h0)
    else $error("config spare bits set");
  stat_fields_a: assert property (
    i_rd && i_addr == WWD_OFS_STATUS |=> o_rdata[31:1] == 31'h0)
    else $error("status spare bits set");
  pulse_width_a: assert property (
    o_sys_reset_req |=> !o_sys_reset_req) else $error("reset pulse long");
  stopped_quiet_a: assert property (
    !run_reg |-> !o_sys_reset_req) else $error("reset while stopped");
  soft_irq_a: assert property (
    i_soft_reset |-> ##2 !o_irq) else $error("irq after soft reset");

  cover property (o_irq);
  cover property (o_sys_reset_req);
  cover property (i_wr && i_addr == WWD_OFS_CONTROL ##1 o_sys_reset_req);
endmodule : wwd_chk

bind wwd_top wwd_chk wwd_chk_i (.*);
`default_nettype wire

//--- verif/wwd_top_tb.sv
// Purpose: self-checking bench for wwd_top
// Assumes: 50 MHz clock, full 4096 base count
// Notes: divider drawn from codes 00 and 01 to bound run time
`timescale 1ns/1ps
`default_nettype none
module wwd_top_tb;
  import wwd_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_soft_reset = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_debug_freeze_select = 1'b0;
  logic i_core_halted = 1'b0;
  logic [WWD_ADDR_W-1:0] i_addr = '0;
  logic [31:0] i_wdata = '0;
  logic [31:0] o_rdata;
  logic o_sys_reset_req;
  logic o_irq;
  logic [6:0] v;
  int err_count = 0;
  int checked = 0;
  int d;
  int p;
  int n;

  wwd_top wwd_top_i (.i_clk, .i_reset_n, .i_soft_reset, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_debug_freeze_select, .i_core_halted,
    .o_sys_reset_req, .o_irq);

  initial begin
    forever #10 i_clk = ~i_clk;
  end

  function automatic logic [31:0] ctl(input logic r, input logic [6:0] c);
    return {24'h0, r, c};
  endfunction : ctl

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= dt;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask : rchk

  task automatic end_sim;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  initial begin
    repeat (100000) @(posedge i_clk);
    err_count++;
    end_sim();
  end

  initial begin
    void'($urandom(29357));
    d = $urandom % 2;
    p = 4096 << d;
    v = 7'h40 + 7'($urandom % 16);
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rchk(WWD_OFS_CONTROL, 32'h7F);
    rchk(WWD_OFS_CONFIG, 32'h7F);
    rchk(WWD_OFS_STATUS, 32'h0);
    rchk(8'h14, 32'h0);
    wr(WWD_OFS_CONTROL, 32'h0);
    rchk(WWD_OFS_CONTROL, ctl(1'b0, 7'h00));
    wr(WWD_OFS_CONFIG, {22'h0, 1'b1, d[1:0], 7'h7F});
    wr(WWD_OFS_IRQ_EN, 32'h1);
    // three ticks: 0x41, 0x40 raises the warning, 0x3F trips
    wr(WWD_OFS_CONTROL, 32'hC2);
    chk(o_sys_reset_req, 1'b0);
    n = 0;
    while (o_irq !== 1'b1 && n < 3 * p) begin
      @(posedge i_clk);
      #1 n++;
    end
    chk(o_irq, 1'b1);
    n = 0;
    while (o_sys_reset_req !== 1'b1 && n < 2 * p) begin
      @(posedge i_clk);
      #1 n++;
    end
    chk(n, p - 1);
    rchk(WWD_OFS_CONTROL, ctl(1'b1, 7'h3F));
    rchk(WWD_OFS_STATUS, 32'h1);
    wr(WWD_OFS_STATUS, 32'h1);
    rchk(WWD_OFS_STATUS, 32'h1);
    wr(WWD_OFS_IRQ_EN, 32'h0);
    rchk(WWD_OFS_STATUS, 32'h1);
    chk(o_irq, 1'b0);
    wr(WWD_OFS_IRQ_EN, 32'h1);
    rchk(WWD_OFS_STATUS, 32'h1);
    chk(o_irq, 1'b1);
    wr(WWD_OFS_STATUS, 32'h0);
    rchk(WWD_OFS_STATUS, 32'h0);
    chk(o_irq, 1'b0);
    @(posedge i_clk);
    i_debug_freeze_select <= 1'b1;
    i_core_halted <= 1'b1;
    repeat (p + 8) @(posedge i_clk);
    rchk(WWD_OFS_CONTROL, ctl(1'b1, 7'h3F));
    wr(WWD_OFS_CONFIG, {22'h0, 1'b0, d[1:0], 7'h50});
    rchk(WWD_OFS_CONFIG, {22'h0, 1'b1, d[1:0], 7'h50});
    wr(WWD_OFS_CONTROL, 32'h7F);
    chk(o_sys_reset_req, 1'b0);
    rchk(WWD_OFS_CONTROL, ctl(1'b1, 7'h7F));
    wr(WWD_OFS_CONTROL, {25'h0, v});
    chk(o_sys_reset_req, 1'b1);
    wr(WWD_OFS_CONTROL, {25'h0, v});
    chk(o_sys_reset_req, 1'b0);
    @(posedge i_clk);
    i_soft_reset <= 1'b1;
    @(posedge i_clk);
    i_soft_reset <= 1'b0;
    rchk(WWD_OFS_CONFIG, 32'h7F);
    rchk(WWD_OFS_CONTROL, 32'h7F);
    end_sim();
  end
endmodule : wwd_top_tb
`default_nettype wire
